// ==== src/mcr_modulator_config.sv ====
// Modulator configuration bank: carrier word, symbol rate, format, Manchester and sync mode.
// Assumes a host on the serial port and a modulator that marks frame start and frame end.
`timescale 1ns/10ps
`include "mcr_defs.svh"

module mcr_modulator_config
  import mcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        csn,
  input  wire logic        mosi,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  output logic             miso,
  output logic             miso_oe,
  output logic [23:0]      carrier_base_word,
  output logic [3:0]       rate_exponent,
  output logic [7:0]       rate_mantissa,
  output logic [2:0]       modulation_select,
  output logic             manchester_en,
  output logic [2:0]       sync_mode,
  output logic [1:0]       sync_word_count,
  output logic             frame_active,
  output logic             symbol_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [5:0] reg_addr;
  logic       wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  mcr_spi_port u_port (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .sclk     (sclk),
    .csn      (csn),
    .mosi     (mosi),
    .rd_data  (rd_data),
    .reg_addr (reg_addr),
    .wr_pulse (wr_pulse),
    .wr_data  (wr_data),
    .miso     (miso),
    .miso_oe  (miso_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Host-visible registers
  logic [5:0] carrier_word_high, next_carrier_word_high;
  logic [7:0] carrier_word_mid, next_carrier_word_mid;
  logic [7:0] carrier_word_low, next_carrier_word_low;
  logic [3:0] host_exp, next_host_exp;
  logic [7:0] host_mant, next_host_mant;
  logic [2:0] host_mod, next_host_mod;
  logic       host_manch, next_host_manch;
  logic [2:0] host_sync, next_host_sync;

  // Count of sync words sent for a sync mode: none, one or repeated
  function automatic logic [1:0] sync_words(input logic [2:0] mode);
    logic [1:0] n;
    n = 2'h0;
    if (mode[1:0] == 2'h0) begin
      n = 2'h0;
    end else if (mode[1:0] == 2'h3) begin
      n = 2'h2;
    end else begin
      n = 2'h1;
    end
    return n;
  endfunction

  // Write decode; reserved bits are simply not stored
  always_comb begin
    next_carrier_word_high = carrier_word_high;
    next_carrier_word_mid  = carrier_word_mid;
    next_carrier_word_low  = carrier_word_low;
    next_host_exp          = host_exp;
    next_host_mant         = host_mant;
    next_host_mod          = host_mod;
    next_host_manch        = host_manch;
    next_host_sync         = host_sync;
    if (wr_pulse) begin
      if (reg_addr == `MCR_OFS_WORD_HIGH) begin
        next_carrier_word_high = wr_data[5:0];
      end else if (reg_addr == `MCR_OFS_WORD_MID) begin
        next_carrier_word_mid = wr_data;
      end else if (reg_addr == `MCR_OFS_WORD_LOW) begin
        next_carrier_word_low = wr_data;
      end else if (reg_addr == `MCR_OFS_RATE_EXP) begin
        next_host_exp = wr_data[3:0];
      end else if (reg_addr == `MCR_OFS_RATE_MANT) begin
        next_host_mant = wr_data;
      end else if (reg_addr == `MCR_OFS_FMT_SYNC) begin
        next_host_mod   = wr_data[`MCR_POS_MOD_SEL +: 3];
        next_host_manch = wr_data[`MCR_POS_MANCH];
        next_host_sync  = wr_data[`MCR_POS_SYNC +: 3];
      end
    end
  end

  // Read decode; unmapped addresses and reserved bits return zero
  always_comb begin
    rd_data = 8'h00;
    if (reg_addr == `MCR_OFS_WORD_HIGH) begin
      rd_data = {2'h0, carrier_word_high};
    end else if (reg_addr == `MCR_OFS_WORD_MID) begin
      rd_data = carrier_word_mid;
    end else if (reg_addr == `MCR_OFS_WORD_LOW) begin
      rd_data = carrier_word_low;
    end else if (reg_addr == `MCR_OFS_RATE_EXP) begin
      rd_data = {4'h0, host_exp};
    end else if (reg_addr == `MCR_OFS_RATE_MANT) begin
      rd_data = host_mant;
    end else if (reg_addr == `MCR_OFS_FMT_SYNC) begin
      rd_data = {1'b0, host_mod, host_manch, host_sync};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      carrier_word_high <= `MCR_RST_WORD_HIGH;
      carrier_word_mid  <= `MCR_RST_WORD_MID;
      carrier_word_low  <= `MCR_RST_WORD_LOW;
      host_exp          <= `MCR_RST_RATE_EXP;
      host_mant         <= `MCR_RST_RATE_MANT;
      host_mod          <= `MCR_RST_MOD_SEL;
      host_manch        <= `MCR_RST_MANCH;
      host_sync         <= `MCR_RST_SYNC_MODE;
    end else if (ce) begin
      carrier_word_high <= next_carrier_word_high;
      carrier_word_mid  <= next_carrier_word_mid;
      carrier_word_low  <= next_carrier_word_low;
      host_exp          <= next_host_exp;
      host_mant         <= next_host_mant;
      host_mod          <= next_host_mod;
      host_manch        <= next_host_manch;
      host_sync         <= next_host_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Applied settings: rate, format, Manchester and sync are latched only at a frame start outside a frame,
  // so a host write to them never reshapes a frame already on the air; the carrier word follows the registers at once
  logic       load;
  logic       next_frame_active;
  logic [3:0] next_rate_exponent;
  logic [7:0] next_rate_mantissa;
  logic [2:0] next_modulation_select;
  logic       next_manchester_en;
  logic [2:0] next_sync_mode;
  logic [1:0] next_sync_word_count;
  logic [23:0] next_carrier_base_word;

  assign load = frame_start & ~frame_active;

  always_comb begin
    next_frame_active      = frame_active;
    next_rate_exponent     = rate_exponent;
    next_rate_mantissa     = rate_mantissa;
    next_modulation_select = modulation_select;
    next_manchester_en     = manchester_en;
    next_sync_mode         = sync_mode;
    next_sync_word_count   = sync_word_count;
    // Carrier word follows the registers at once; the synthesiser retunes between frames anyway
    next_carrier_base_word = {2'h0, carrier_word_high, carrier_word_mid, carrier_word_low};
    if (load) begin
      next_frame_active      = 1'b1;
      next_rate_exponent     = host_exp;
      next_rate_mantissa     = host_mant;
      next_modulation_select = host_mod;
      next_manchester_en     = host_manch;
      next_sync_mode         = host_sync;
      next_sync_word_count   = sync_words(host_sync);
    end else if (frame_end) begin
      next_frame_active = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_active      <= 1'b0;
      rate_exponent     <= `MCR_RST_RATE_EXP;
      rate_mantissa     <= `MCR_RST_RATE_MANT;
      modulation_select <= `MCR_RST_MOD_SEL;
      manchester_en     <= `MCR_RST_MANCH;
      sync_mode         <= `MCR_RST_SYNC_MODE;
      sync_word_count   <= 2'h1;
      carrier_base_word <= {2'h0, `MCR_RST_WORD_HIGH, `MCR_RST_WORD_MID, `MCR_RST_WORD_LOW};
    end else if (ce) begin
      frame_active      <= next_frame_active;
      rate_exponent     <= next_rate_exponent;
      rate_mantissa     <= next_rate_mantissa;
      modulation_select <= next_modulation_select;
      manchester_en     <= next_manchester_en;
      sync_mode         <= next_sync_mode;
      sync_word_count   <= next_sync_word_count;
      carrier_base_word <= next_carrier_base_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Symbol-rate generator: 28-bit fractional accumulator, carry is the symbol tick.
  // Restarted at each frame start outside a frame so the first symbol has a full period.
  logic [`MCR_RATE_FRAC_W-1:0] rate_acc, next_rate_acc;
  logic [`MCR_RATE_FRAC_W:0]   rate_sum;
  logic [`MCR_RATE_FRAC_W-1:0] rate_step;
  logic                        next_symbol_tick;

  // Hidden ninth mantissa bit, then scaled by two to the exponent
  // Widened before the shift so no exponent can push bits off the top
  assign rate_step = `MCR_RATE_FRAC_W'(`MCR_RATE_HIDDEN | {1'b0, rate_mantissa})
                     << rate_exponent;
  assign rate_sum  = {1'b0, rate_acc} + {1'b0, rate_step};

  always_comb begin
    next_rate_acc    = rate_acc;
    next_symbol_tick = 1'b0;
    if (load) begin
      next_rate_acc = '0;
    end else if (frame_active) begin
      next_rate_acc    = rate_sum[`MCR_RATE_FRAC_W-1:0];
      next_symbol_tick = rate_sum[`MCR_RATE_FRAC_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rate_acc    <= '0;
      symbol_tick <= 1'b0;
    end else if (ce) begin
      rate_acc    <= next_rate_acc;
      symbol_tick <= next_symbol_tick;
    end
  end

endmodule

// ==== src/mcr_defs.svh ====
// Offsets, field positions, reset values and widths of the modulator configuration bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// Register addresses on the serial port
`define MCR_ADDR_W          6
`define MCR_OFS_WORD_HIGH   6'h0D
`define MCR_OFS_WORD_MID    6'h0E
`define MCR_OFS_WORD_LOW    6'h0F
`define MCR_OFS_RATE_EXP    6'h10
`define MCR_OFS_RATE_MANT   6'h11
`define MCR_OFS_FMT_SYNC    6'h12

// Reset values
`define MCR_RST_WORD_HIGH   6'h1E
`define MCR_RST_WORD_MID    8'hC4
`define MCR_RST_WORD_LOW    8'hEC
`define MCR_RST_RATE_EXP    4'hC
`define MCR_RST_RATE_MANT   8'h22
`define MCR_RST_MOD_SEL     3'h0
`define MCR_RST_MANCH       1'h0
`define MCR_RST_SYNC_MODE   3'h2

// Field positions inside the format/sync register
`define MCR_POS_MOD_SEL     4
`define MCR_POS_MANCH       3
`define MCR_POS_SYNC        0

// Serial header byte: bit 7 read, bits 5:0 address
`define MCR_HDR_READ_BIT    7

// Symbol rate accumulator: rate = (256+M)*2^E/2^28 * f_clk
`define MCR_RATE_HIDDEN     9'h100
`define MCR_RATE_FRAC_W     28

`endif

// ==== src/mcr_pkg.sv ====
// Types shared by the modulator configuration bank.
// Assumes mcr_defs.svh supplies the numeric constants.
package mcr_pkg;

  // Modulation formats; unlisted codes have no defined use
  typedef enum logic [2:0] {
    MCR_MOD_FSK2 = 3'h0,
    MCR_MOD_GFSK = 3'h1,
    MCR_MOD_ASK  = 3'h3,
    MCR_MOD_MSK  = 3'h7
  } mcr_mod_e;

  // Serial transaction phases
  typedef enum logic {
    MCR_PH_HEADER,
    MCR_PH_DATA
  } mcr_phase_e;

endpackage

// ==== src/mcr_spi_port.sv ====
// Serial configuration port: header byte then data bytes, MSB first, mode 0.
// Assumes sclk half period spans at least four core_clk cycles.
`timescale 1ns/10ps
`include "mcr_defs.svh"

module mcr_spi_port
  import mcr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       csn,
  input  wire logic       mosi,
  input  wire logic [7:0] rd_data,
  output logic [5:0]      reg_addr,
  output logic            wr_pulse,
  output logic [7:0]      wr_data,
  output logic            miso,
  output logic            miso_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] s1, s2, s3, filt;
  logic [2:0] next_filt;
  logic [7:0] sh_in, next_sh_in, tx_sh, next_tx_sh;
  logic [2:0] bit_cnt, next_bit_cnt;
  mcr_phase_e phase, next_phase;
  logic       is_read, next_is_read;
  logic       load_pend, next_load_pend;
  logic       adv_pend, next_adv_pend;
  logic       next_miso;
  logic [5:0] next_reg_addr;
  logic       next_wr_pulse;
  logic [7:0] next_wr_data;
  logic       rise, fall, sel;

  // Three-stage pin synchronisers; the filtered level moves only when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1 <= 3'h7;
      s2 <= 3'h7;
      s3 <= 3'h7;
    end else if (ce) begin
      s1 <= {csn, sclk, mosi};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Edges are judged on the filtered level so a glitch never clocks a bit
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
  end
  assign sel  = ~next_filt[2];
  assign rise = next_filt[1] & ~filt[1];
  assign fall = ~next_filt[1] & filt[1];

  // Shift, byte framing, write strobe and burst address increment
  always_comb begin
    next_sh_in     = sh_in;
    next_tx_sh     = tx_sh;
    next_bit_cnt   = bit_cnt;
    next_phase     = phase;
    next_is_read   = is_read;
    next_load_pend = 1'b0;
    next_adv_pend  = 1'b0;
    next_miso      = miso;
    next_reg_addr  = reg_addr;
    next_wr_pulse  = 1'b0;
    next_wr_data   = wr_data;
    if (!sel) begin
      // Deselect drops any partial byte
      next_bit_cnt = 3'h0;
      next_phase   = MCR_PH_HEADER;
      next_tx_sh   = 8'h00;
      next_miso    = 1'b0;
    end else begin
      if (load_pend) begin
        next_tx_sh = rd_data; // Address settled one cycle earlier
      end
      // Step the burst address only after the write strobe has used it
      if (adv_pend) begin
        next_reg_addr  = 6'(reg_addr + 6'h01);
        next_load_pend = 1'b1;
      end
      if (rise) begin
        next_sh_in   = {sh_in[6:0], next_filt[0]};
        next_bit_cnt = 3'(bit_cnt + 3'h1);
        if (bit_cnt == 3'h7) begin
          if (phase == MCR_PH_HEADER) begin
            next_reg_addr  = next_sh_in[5:0];
            next_is_read   = next_sh_in[`MCR_HDR_READ_BIT];
            next_phase     = MCR_PH_DATA;
            next_load_pend = 1'b1;
          end else begin
            next_wr_pulse  = ~is_read;
            next_wr_data   = next_sh_in;
            next_adv_pend  = 1'b1;
          end
        end
      end else if (fall && !load_pend) begin
        // Mode 0: the bit goes out on the fall ahead of the rise that samples it
        next_miso  = tx_sh[7];
        next_tx_sh = {tx_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      filt      <= 3'h7;
      sh_in     <= 8'h00;
      tx_sh     <= 8'h00;
      bit_cnt   <= 3'h0;
      phase     <= MCR_PH_HEADER;
      is_read   <= 1'b0;
      load_pend <= 1'b0;
      adv_pend  <= 1'b0;
      reg_addr  <= 6'h00;
      wr_pulse  <= 1'b0;
      wr_data   <= 8'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else if (ce) begin
      filt      <= next_filt;
      sh_in     <= next_sh_in;
      tx_sh     <= next_tx_sh;
      bit_cnt   <= next_bit_cnt;
      phase     <= next_phase;
      is_read   <= next_is_read;
      load_pend <= next_load_pend;
      adv_pend  <= next_adv_pend;
      reg_addr  <= next_reg_addr;
      wr_pulse  <= next_wr_pulse;
      wr_data   <= next_wr_data;
      miso      <= next_miso;
      miso_oe   <= sel;
    end
  end

endmodule

// ==== dv/mcr_modulator_config_monitor.sv ====
// Checker on the top ports of the modulator configuration bank.
// Assumes a single core clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module mcr_modulator_config_monitor (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        csn,
  input wire logic        miso_oe,
  input wire logic        frame_start,
  input wire logic        frame_end,
  input wire logic [23:0] carrier_base_word,
  input wire logic [3:0]  rate_exponent,
  input wire logic [7:0]  rate_mantissa,
  input wire logic [2:0]  modulation_select,
  input wire logic        manchester_en,
  input wire logic [2:0]  sync_mode,
  input wire logic [1:0]  sync_word_count,
  input wire logic        frame_active,
  input wire logic        symbol_tick
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////
  // A start only counts while idle; a start in mid-frame must do nothing
  sequence s_accept;
    ce && frame_start && !frame_active;
  endsequence
  sequence s_no_tick;
    !symbol_tick [*8];
  endsequence
  // Select pin held long enough to pass the three-stage synchroniser
  sequence s_csn_idle;
    csn [*5];
  endsequence
  sequence s_csn_sel;
    !csn [*6];
  endsequence

  a_active_set: assert property (s_accept |=> frame_active)
    else $error("accepted start did not open a frame");
  a_active_clear: assert property (ce && frame_active && frame_end |=> !frame_active)
    else $error("frame end did not close the frame");
  a_idle_hold: assert property (!frame_active && !frame_start |=> !frame_active)
    else $error("frame opened without a start");
  a_applied_hold: assert property ((!frame_start || frame_active) |=>
    $stable({rate_exponent, rate_mantissa, modulation_select, manchester_en, sync_mode}))
    else $error("applied settings moved outside an accepted start");
  a_sync_count: assert property (sync_word_count == ((sync_mode[1:0] == 2'h0) ? 2'h0 :
    (sync_mode[1:0] == 2'h3) ? 2'h2 : 2'h1))
    else $error("sync word count does not follow sync mode");
  a_word_top: assert property (carrier_base_word[23:22] == 2'h0)
    else $error("carrier word top bits not zero");
  a_tick_active: assert property (symbol_tick |-> $past(frame_active))
    else $error("symbol tick outside a frame");
  // Largest step is 511 shifted by 15, so no carry within 8 adds of a cleared sum
  a_tick_fresh: assert property (s_accept |=> s_no_tick)
    else $error("symbol tick too soon after frame start");
  a_oe_idle: assert property (s_csn_idle |-> !miso_oe)
    else $error("serial output driven while deselected");
  a_oe_select: assert property (s_csn_sel |-> miso_oe)
    else $error("serial output not driven while selected");
endmodule

bind mcr_modulator_config mcr_modulator_config_monitor i_mon (.core_clk, .srst, .ce, .csn,
  .miso_oe, .frame_start,
  .frame_end, .carrier_base_word, .rate_exponent, .rate_mantissa, .modulation_select,
  .manchester_en, .sync_mode, .sync_word_count, .frame_active, .symbol_tick);

// ==== dv/mcr_host_model.sv ====
// Host model: a microcontroller driving the serial configuration port.
// Assumes core_clk from the bench; sclk half period is eight core cycles.
`timescale 1ns/10ps
module mcr_host_model (
  input  wire logic core_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      csn,
  output logic      mosi
);
  // Idle port: deselected, clock low
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One byte MSB first; miso taken at the edge that raises sclk
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (8) @(posedge core_clk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (7) @(posedge core_clk);
    end
  endtask

  // Header then one data byte; mosi toggled once deselected so no stale level lingers
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    @(posedge core_clk);
    csn <= 1'b0;
    xbyte(hdr, junk);
    xbyte(wd, rd);
    repeat (8) @(posedge core_clk);
    sclk <= 1'b0;
    repeat (8) @(posedge core_clk);
    csn  <= 1'b1;
    mosi <= ~mosi;
    repeat (16) @(posedge core_clk);
  endtask
endmodule

// ==== dv/test_modulator_config_registers.sv ====
// Self-checking bench for the modulator configuration bank.
// Assumes design, defines header, host model and checker compiled before it.
`timescale 1ns/10ps
module test_modulator_config_registers;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        frame_start = 1'b0;
  logic        frame_end = 1'b0;
  logic        sclk, csn, mosi, miso, miso_oe, manchester_en, frame_active, symbol_tick;
  logic [23:0] carrier_base_word;
  logic [3:0]  rate_exponent;
  logic [7:0]  rate_mantissa;
  logic [2:0]  modulation_select, sync_mode;
  logic [1:0]  sync_word_count;
  int          bad_count = 0;
  int          num_checks = 0;
  int          mdl [int];
  int          ae, am, af, act;

  always #4 core_clk = ~core_clk;

  mcr_modulator_config i_dut (.core_clk, .srst, .ce, .sclk, .csn, .mosi, .frame_start,
    .frame_end, .miso, .miso_oe, .carrier_base_word, .rate_exponent, .rate_mantissa,
    .modulation_select, .manchester_en, .sync_mode, .sync_word_count, .frame_active,
    .symbol_tick);
  mcr_host_model i_host (.core_clk, .miso, .sclk, .csn, .mosi);

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Writable bits per address; zero marks an unmapped place
  function automatic int msk(input int a);
    case (a)
      8'h0D: return 8'h3F;
      8'h0E, 8'h0F, 8'h11: return 8'hFF;
      8'h10: return 8'h0F;
      8'h12: return 8'h7F;
      default: return 0;
    endcase
  endfunction

  task automatic wr(input int a, input int d);
    logic [7:0] r;
    i_host.xfer(8'(a), 8'(d), r);
    if (msk(a) != 0)
      mdl[a] = d & msk(a);
  endtask

  task automatic rd(input int a);
    logic [7:0] r;
    i_host.xfer(8'(a) | 8'h80, 8'h00, r);
    chk("readback", mdl.exists(a) ? mdl[a] : 0, r);
  endtask

  // Settings are sampled only by a start that finds the modulator idle
  task automatic start_frame();
    @(posedge core_clk);
    frame_start <= 1'b1;
    if (!act) begin
      ae = mdl[8'h10];
      am = mdl[8'h11];
      af = mdl[8'h12];
    end
    act = 1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("active", 1, frame_active);
  endtask

  task automatic end_frame();
    @(posedge core_clk);
    frame_end <= 1'b1;
    act = 0;
    @(posedge core_clk);
    frame_end <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("idle", 0, frame_active);
  endtask

  task automatic chk_app();
    int s;
    s = af & 3;
    chk("exponent", ae, rate_exponent);
    chk("mantissa", am, rate_mantissa);
    chk("format", af >> 4, modulation_select);
    chk("manchester", (af >> 3) & 1, manchester_en);
    chk("sync", af & 7, sync_mode);
    chk("sync count", s == 0 ? 0 : s == 3 ? 2 : 1, sync_word_count);
  endtask

  // Gap between two ticks is 2^28 over the step when the step divides it
  task automatic tick_gap();
    int n;
    start_frame();
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (symbol_tick !== 1'b1 || n == 0) begin
        @(negedge core_clk);
        n++;
        if (n > 5000) begin
          bad_count++;
          test_done();
        end
      end
    end
    chk("tick gap", (1 << 28) / ((256 + am) << ae), n);
    end_frame();
  endtask

  initial begin
    #800000;
    bad_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(57068));
    mdl[8'h0D] = 8'h1E;
    mdl[8'h0E] = 8'hC4;
    mdl[8'h0F] = 8'hEC;
    mdl[8'h10] = 8'h0C;
    mdl[8'h11] = 8'h22;
    mdl[8'h12] = 8'h02;
    ae = mdl[8'h10];
    am = mdl[8'h11];
    af = mdl[8'h12];
    act = 0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("base word", 32'h1EC4EC, carrier_base_word);
    chk_app();
    for (int a = 8'h0D; a <= 8'h12; a++)
      rd(a);
    // Random data with the top bits forced, unmapped neighbours included
    for (int a = 8'h0C; a <= 8'h13; a++) begin
      wr(a, $urandom_range(255) | 8'hC0);
      rd(a);
    end
    chk("base word", (mdl[8'h0D] << 16) | (mdl[8'h0E] << 8) | mdl[8'h0F], carrier_base_word);
    chk_app();
    // Every format and sync code; a second start in mid-frame must be ignored
    for (int c = 0; c < 8; c++) begin
      wr(8'h12, (c << 4) | ((c & 1) << 3) | (7 - c));
      start_frame();
      chk_app();
      wr(8'h12, 8'h00);
      start_frame();
      chk_app();
      end_frame();
    end
    wr(8'h11, 8'h00);
    for (int e = 13; e <= 15; e++) begin
      wr(8'h10, e);
      tick_gap();
    end
    // Enable held low: a start must be ignored and every setting frozen
    @(posedge core_clk);
    ce          <= 1'b0;
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("frozen", 0, frame_active);
    chk_app();
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk("frozen", 0, frame_active);
    chk("oe idle", 0, miso_oe);
    test_done();
  end
endmodule
